// File: rtl/cgp_pin_ctrl.sv
// Control logic for multi_function_pin_b: function select, GPIO and interrupt output
// Notes on behaviour
// RULE1 - 4-bit selector, zero disables, one reserved
// RULE2 - Code two: headset detect interrupt, ~1.75 ms
// RULE3 - Code three input, code four output
// RULE4 - Codes five-seven: microphone data, both clock edges
// RULE5 - Code eight: bit clock, direction set elsewhere
// RULE6 - Nine: headset|button; ten adds short, noise
// RULE7 - Eleven: short|noise; twelve: headset|button|short
// RULE8 - Thirteen: short-circuit interrupt alone
// RULE9 - Fifteen: button interrupt alone
// RULE10 - Output mode drives pin per output bit
// RULE11 - Read-only input bit reflects pin level
// RULE12 - Duration bit: single 2ms pulse or repeating
// RULE13 - Bit zero reserved, read-only, never written
// RULE14 - Code fourteen reserved, pin kept inactive
`timescale 1ns/10ps
`default_nettype none

module cgp_pin_ctrl
   import cgp_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire cgp_wr_s     reg_wr_i,
   input  wire logic [6:0]  reg_rd_addr_i,
   input  wire logic        flags_read_i,
   input  wire cgp_events_s events_i,
   input  wire logic        pin_in_i,
   input  wire logic        bclk_out_i,
   input  wire logic        bclk_dir_out_i,
   output logic [7:0]       reg_rdata_o,
   output logic             pin_out_o,
   output logic             pin_oe_n_o,
   output logic             dmic_data_o,
   output logic             dmic_valid_o,
   output logic             bclk_in_o,
   input  wire logic        dmic_clk_i
);

   ////////////////////////////////////////////////////////////////////////////
   logic [3:0]        sel;
   logic              out_val;
   logic              dur_repeat;
   logic [1:0]        pin_sync;
   logic [1:0]        dclk_sync;
   logic              dclk_last;
   logic              int_src;
   logic              int_src_q;
   logic              int_pend;
   logic [CGP_CNT_W-1:0] pulse_cnt;
   logic              int_line;
   logic [CGP_CNT_W-1:0] pulse_len;

   // Register write; bit zero and input bit are not storage
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         sel        <= CGP_REG_RESET[CGP_SEL_HI:CGP_SEL_LO];
         out_val    <= CGP_REG_RESET[CGP_OUT_BIT];
         dur_repeat <= CGP_REG_RESET[CGP_DUR_BIT];
      end
      else if (reg_wr_i.wr && reg_wr_i.addr == CGP_REG_OFFSET)
      begin
         sel        <= reg_wr_i.wdata[CGP_SEL_HI:CGP_SEL_LO]; // RULE1
         out_val    <= reg_wr_i.wdata[CGP_OUT_BIT];
         dur_repeat <= reg_wr_i.wdata[CGP_DUR_BIT];
      end
   end

   // Pin and microphone clock come from outside: two flops first
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pin_sync  <= 2'h0;
         dclk_sync <= 2'h0;
         dclk_last <= 1'b0;
      end
      else
      begin
         pin_sync  <= {pin_sync[0], pin_in_i};
         dclk_sync <= {dclk_sync[0], dmic_clk_i};
         dclk_last <= dclk_sync[1];
      end
   end

   // Read data; reserved bit zero always reads zero
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
         reg_rdata_o <= CGP_REG_RESET;
      else if (reg_rd_addr_i == CGP_REG_OFFSET)
         reg_rdata_o <= {sel, out_val, pin_sync[1], dur_repeat, 1'b0}; // RULE11 RULE13
      else
         reg_rdata_o <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt source chosen by selector
   always_comb
   begin
      int_src = 1'b0;
      case (cgp_sel_e'(sel))
         CGP_INT_HS:  int_src = events_i.headset; // RULE2
         CGP_INT_HB:  int_src = events_i.headset | events_i.button; // RULE6
         CGP_INT_ALL: int_src = |events_i; // RULE6
         CGP_INT_SA:  int_src = events_i.short_ckt | events_i.auto_gain_loop; // RULE7
         CGP_INT_HBS: int_src = events_i.headset | events_i.button
                                | events_i.short_ckt; // RULE7
         CGP_INT_SC:  int_src = events_i.short_ckt; // RULE8
         CGP_INT_BTN: int_src = events_i.button; // RULE9
         default:     int_src = 1'b0; // RULE14
      endcase
   end

   // Headset-only code uses its shorter typical pulse
   assign pulse_len = (cgp_sel_e'(sel) == CGP_INT_HS) ?
                      CGP_CNT_W'(CGP_HS_PULSE_CYC) : CGP_CNT_W'(CGP_PULSE_CYC);

   // Pulse timer; repeat mode re-arms until the flags register is read
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         int_src_q <= 1'b0;
         int_pend  <= 1'b0;
         pulse_cnt <= '0;
         int_line  <= 1'b0;
      end
      else
      begin
         int_src_q <= int_src;
         // New event wins over a flags read in the same cycle
         if (int_src && !int_src_q)
            int_pend <= 1'b1;
         else if (flags_read_i || !dur_repeat)
            int_pend <= 1'b0;
         if (pulse_cnt > CGP_CNT_W'(1))
         begin
            pulse_cnt <= pulse_cnt - 1'b1;
         end
         else if (pulse_cnt == CGP_CNT_W'(1))
         begin
            // Phase end: a pending repeat alternates equal high and low phases,
            // so the host sees separate pulses rather than a stuck-high line
            pulse_cnt <= '0;
            int_line  <= 1'b0;
            if (dur_repeat && int_pend && !flags_read_i)
            begin
               pulse_cnt <= pulse_len; // RULE12
               int_line  <= ~int_line;
            end
         end
         else if ((int_src && !int_src_q) || (dur_repeat && int_pend && !flags_read_i))
         begin
            pulse_cnt <= pulse_len; // RULE12
            int_line  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive: output enable is active low
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pin_out_o  <= 1'b0;
         pin_oe_n_o <= 1'b1;
      end
      else
      begin
         case (cgp_sel_e'(sel))
            CGP_GP_OUT:
            begin
               pin_out_o  <= out_val; // RULE3 RULE10
               pin_oe_n_o <= 1'b0;
            end
            CGP_BCLK:
            begin
               pin_out_o  <= bclk_out_i; // RULE5
               pin_oe_n_o <= ~bclk_dir_out_i;
            end
            CGP_INT_HS, CGP_INT_HB, CGP_INT_ALL, CGP_INT_SA,
            CGP_INT_HBS, CGP_INT_SC, CGP_INT_BTN:
            begin
               pin_out_o  <= int_line;
               pin_oe_n_o <= 1'b0;
            end
            default:
            begin
               pin_out_o  <= 1'b0; // RULE1 RULE14
               pin_oe_n_o <= 1'b1;
            end
         endcase
      end
   end

   // Microphone data on both clock edges; bit clock input path
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         dmic_data_o  <= 1'b0;
         dmic_valid_o <= 1'b0;
         bclk_in_o    <= 1'b0;
      end
      else
      begin
         dmic_valid_o <= 1'b0;
         if ((sel == CGP_DMIC_A || sel == CGP_DMIC_B || sel == CGP_DMIC_C)
             && (dclk_sync[1] != dclk_last))
         begin
            dmic_data_o  <= pin_sync[1]; // RULE4
            dmic_valid_o <= 1'b1;
         end
         bclk_in_o <= (sel == CGP_BCLK) && !bclk_dir_out_i && pin_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_GPOUT_DRIVE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE10
      (sel == CGP_GP_OUT) |=> (!pin_oe_n_o && pin_out_o == $past(out_val)))
      else $error("gp output not driven from value bit");

   AST_DISABLED_IDLE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE14
      (sel == CGP_DISABLED || sel == CGP_RSV_E) |=> pin_oe_n_o)
      else $error("disabled pin is driven");

   AST_INPUT_BIT: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE11
      (reg_rd_addr_i == CGP_REG_OFFSET) |=>
      (reg_rdata_o[CGP_IN_BIT] == $past(pin_sync[1])))
      else $error("input bit does not follow pin");

   AST_RSV_ZERO: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE13
      !reg_rdata_o[CGP_RSV_BIT])
      else $error("reserved bit reads one");

   AST_INT_START: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE12
      (int_src && !int_src_q && pulse_cnt == '0) |=> int_line)
      else $error("interrupt pulse did not start");

   AST_REPEAT_GAP: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE12
      (pulse_cnt == CGP_CNT_W'(1) && int_line && dur_repeat && int_pend && !flags_read_i)
      |=> (!int_line && pulse_cnt != '0))
      else $error("repeat pulse has no low gap");

   AST_HS_SRC: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE2
      (sel == CGP_INT_HS) |-> (int_src == events_i.headset))
      else $error("headset code picks wrong source");

   AST_SC_SRC: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE8
      (sel == CGP_INT_SC) |-> (int_src == events_i.short_ckt))
      else $error("short code picks wrong source");

   AST_DMIC_EDGE: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RULE4
      (sel == CGP_DMIC_A && dclk_sync[1] != dclk_last) |=> dmic_valid_o)
      else $error("mic sample missed on clock edge");

endmodule

`default_nettype wire

// File: rtl/cgp_pkg.sv
// Constants and types for the second multi-function pin control
package cgp_pkg;

   localparam logic [6:0] CGP_REG_OFFSET = 7'h63;
   localparam logic [7:0] CGP_REG_RESET  = 8'h00;

   localparam int CGP_SEL_HI  = 7;
   localparam int CGP_SEL_LO  = 4;
   localparam int CGP_OUT_BIT = 3;
   localparam int CGP_IN_BIT  = 2;
   localparam int CGP_DUR_BIT = 1;
   localparam int CGP_RSV_BIT = 0;

   localparam int CGP_CLK_MHZ      = 200;
   localparam int CGP_PULSE_US     = 2000;
   localparam int CGP_HS_PULSE_US  = 1750;
   localparam int CGP_PULSE_CYC    = CGP_PULSE_US * CGP_CLK_MHZ;
   localparam int CGP_HS_PULSE_CYC = CGP_HS_PULSE_US * CGP_CLK_MHZ;
   localparam int CGP_CNT_W        = 20;

   typedef enum logic [3:0]
   {
      CGP_DISABLED = 4'b0000,
      CGP_RSV_ONE  = 4'b0001,
      CGP_INT_HS   = 4'b0010,
      CGP_GP_IN    = 4'b0011,
      CGP_GP_OUT   = 4'b0100,
      CGP_DMIC_A   = 4'b0101,
      CGP_DMIC_B   = 4'b0110,
      CGP_DMIC_C   = 4'b0111,
      CGP_BCLK     = 4'b1000,
      CGP_INT_HB   = 4'b1001,
      CGP_INT_ALL  = 4'b1010,
      CGP_INT_SA   = 4'b1011,
      CGP_INT_HBS  = 4'b1100,
      CGP_INT_SC   = 4'b1101,
      CGP_RSV_E    = 4'b1110,
      CGP_INT_BTN  = 4'b1111
   } cgp_sel_e;

   typedef struct packed
   {
      logic headset;
      logic button;
      logic short_ckt;
      logic auto_gain_loop;
   } cgp_events_s;

   typedef struct packed
   {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } cgp_wr_s;

endpackage

// File: dv/cgp_pin_partner.sv
// Outside circuit on the second multi-function pin, with a microphone clock source
`timescale 1ns/10ps
`default_nettype none

module cgp_pin_partner
(
   input  wire logic clk_sys_i,
   input  wire logic pin_out_i,
   input  wire logic pin_oe_n_i,
   input  wire logic ext_level_i,
   input  wire logic mic_run_i,
   output logic      pin_in_o,
   output logic      dmic_clk_o
);
   logic [2:0] div = 3'h0;
   logic       tgl = 1'b0;

   // Device wins only while its enable is low, else the outside level shows
   assign pin_in_o   = pin_oe_n_i ? ext_level_i : pin_out_i;
   assign dmic_clk_o = tgl;

   // Mic clock stands still outside a capture burst
   always_ff @(posedge clk_sys_i)
   begin
      div <= mic_run_i ? div + 3'h1 : 3'h0;
      if (mic_run_i && div == 3'h7)
      begin
         tgl <= ~tgl;
      end
   end
endmodule

`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the second multi-function pin control
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import cgp_pkg::*;

   logic        clk_sys_i = 1'b0;
   logic        rst_i = 1'b1;
   cgp_wr_s     reg_wr = '0;
   logic [6:0]  rd_addr = 7'h63;
   logic        flags_rd = 1'b0;
   cgp_events_s ev = '0;
   logic        bclk_out = 1'b0;
   logic        bclk_dir = 1'b0;
   logic        ext_lvl = 1'b0;
   logic        mic_run = 1'b0;
   logic        pin_in, dmic_clk, pin_out, pin_oe_n, dmic_data, dmic_valid, bclk_in;
   logic [7:0]  rdata;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n;
   // Code one is left out on purpose: host software must never program it
   logic [3:0]  codes [11] = '{4'h2, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'h0, 4'h6, 4'h7, 4'hE};
   logic [3:0]  masks [11] = '{4'h8, 4'hC, 4'hF, 4'h3, 4'hE, 4'h2, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0};

   initial forever #2.5 clk_sys_i = ~clk_sys_i;

   cgp_pin_ctrl uut
   (
      .clk_sys_i      (clk_sys_i),
      .rst_i          (rst_i),
      .reg_wr_i       (reg_wr),
      .reg_rd_addr_i  (rd_addr),
      .flags_read_i   (flags_rd),
      .events_i       (ev),
      .pin_in_i       (pin_in),
      .bclk_out_i     (bclk_out),
      .bclk_dir_out_i (bclk_dir),
      .reg_rdata_o    (rdata),
      .pin_out_o      (pin_out),
      .pin_oe_n_o     (pin_oe_n),
      .dmic_data_o    (dmic_data),
      .dmic_valid_o   (dmic_valid),
      .bclk_in_o      (bclk_in),
      .dmic_clk_i     (dmic_clk)
   );

   cgp_pin_partner far_side
   (
      .clk_sys_i   (clk_sys_i),
      .pin_out_i   (pin_out),
      .pin_oe_n_i  (pin_oe_n),
      .ext_level_i (ext_lvl),
      .mic_run_i   (mic_run),
      .pin_in_o    (pin_in),
      .dmic_clk_o  (dmic_clk)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp)
      begin
         $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
         fail_count++;
      end
   endtask

   // Write to the given register address, then let the outputs settle
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys_i);
      reg_wr.wr <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic rst(input int cyc);
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (cyc) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst(20);
      chk(rdata, CGP_REG_RESET, "reset value");
      wr(7'h63, 8'h48);
      chk(rdata, 8'h4C, "output mode readback");
      chk({pin_oe_n, pin_out}, 8'h01, "output high");
      wr(7'h62, 8'h00);
      chk(rdata, 8'h4C, "other address ignored");
      wr(7'h63, 8'h40);
      chk({pin_oe_n, pin_out}, 8'h00, "output low");
      @(posedge clk_sys_i);
      ext_lvl <= 1'b1;
      wr(7'h63, 8'h32);
      chk(rdata, 8'h36, "input high");
      chk(pin_oe_n, 1'b1, "input mode undriven");
      @(posedge clk_sys_i);
      ext_lvl <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk(rdata, 8'h32, "input low");
      $display("test registers done");

      for (int c = 0; c < 11; c++)
      begin
         for (int e = 0; e < 4; e++)
         begin
            rst(2);
            wr(7'h63, {codes[c], 4'h2});
            @(posedge clk_sys_i);
            ev <= 4'h8 >> e;
            repeat (4) @(posedge clk_sys_i);
            #1;
            chk(pin_out, masks[c][3 - e], "interrupt level");
            chk(pin_oe_n, masks[c] == 4'h0, "pin enable");
            @(posedge clk_sys_i);
            ev <= '0;
            flags_rd <= 1'b1;
            @(posedge clk_sys_i);
            flags_rd <= 1'b0;
         end
      end
      $display("test interrupts done");

      rst(2);
      @(posedge clk_sys_i);
      ext_lvl <= 1'b1;
      wr(7'h63, 8'h50);
      @(posedge clk_sys_i);
      mic_run <= 1'b1;
      n = 0;
      // Far-side clock flips every 8 cycles; each flip shows as valid 3 cycles later
      repeat (70)
      begin
         @(posedge clk_sys_i);
         #1;
         n += int'(dmic_valid === 1'b1);
      end
      chk(n, 8, "mic edges");
      chk(dmic_data, 1'b1, "mic data");
      @(posedge clk_sys_i);
      mic_run <= 1'b0;
      $display("test microphone done");

      wr(7'h63, 8'h80);
      @(posedge clk_sys_i);
      bclk_dir <= 1'b1;
      bclk_out <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk({pin_oe_n, pin_out}, 8'h01, "bit clock out");
      @(posedge clk_sys_i);
      bclk_dir <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      #1;
      chk({pin_oe_n, bclk_in}, 8'h03, "bit clock in");
      $display("test bit clock done");
      end_of_test();
   end

   initial
   begin
      #400000;
      fail_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
